// >>> flash_seq.sv
`timescale 1ns/1ps
// Summary of operation
// R1: with boot enabled, a read stream starts after the reset command. Power-on reset erases the config; only the reset command arms boot.
// R2: boot read waits the delay count, fetches from a 16-byte aligned start.
// R3: boot data follows chip select fall; its rise returns to commands.
// R4: host keeps chip select low for at least one whole boot byte.
// R5: boot stream uses one line if quad_enable is 0, four if 1.
// R6: boot_delay_select 00/01/10/11 gives 7/9/11/13 delay cycles.
// R7: bits 31 to 4 hold the boot start in 16-byte units, erased ones.
// R8: bit 0 of the boot config register enables boot when zero.
// R9: boot config is kept, programmed, erased and read by own commands.
// R10: host limits serial clock according to boot_delay_select.
// R11: sector wipe needs the write latch; it sets a 4K sector to ones.
// R12: sector wipe takes the sector from address bit 12 upward.
// R13: erase is rejected unless chip select rises on the address end.
// R14: host sends opcode then three address bytes inside one select.
// R15: opcode takes 8 clocks single-line, 2 clocks in quad command mode.
// R16: erase self-times after select rise; progress flag, then latch clears.
// R17: erase skips a block guarded by level bits or lock bits.
// R18: half block wipe erases 32K with the same checks.
// R19: block wipe erases 64K with the same checks.
// R20: quad enhance state ends when any indicator bit equals its partner.
// R21: read dummy count follows dummy_count_select.
// R22: erase with write latch clear is ignored entirely.
module flash_seq #(
  parameter int unsigned SECTOR_CYC = 2000,
  parameter int unsigned HALF_CYC   = 8000,
  parameter int unsigned BLOCK_CYC  = 16000,
  parameter int unsigned CFG_CYC    = 1000,
  parameter logic [3:0]  DUMMY0     = 4'h6,
  parameter logic [3:0]  DUMMY1     = 4'h4,
  parameter logic [3:0]  DUMMY2     = 4'h8,
  parameter logic [3:0]  DUMMY3     = 4'hA
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // serial link
  input  wire logic                 cs_n,
  input  wire logic                 sclk,
  input  wire logic [3:0]           io_in,
  output logic      [3:0]           io_out_q,
  output logic      [3:0]           io_oe_q,
  // mode and protection settings
  input  wire logic                 quad_enable,
  input  wire logic                 quad_command_mode,
  input  wire logic                 protect_scheme_select,
  input  wire logic [3:0]           protect_level_bits,
  input  wire logic [255:0]         sector_lock_bits,
  input  wire logic [1:0]           dummy_count_select,
  // status
  output logic                      wip_q,
  output logic                      wel_q,
  output logic                      enhance_q,
  output logic      [3:0]           read_dummy_q,
  output logic      [31:0]          cfg_q,
  // array side
  output logic                      array_rd_q,
  output logic      [23:0]          array_addr_q,
  input  wire logic [7:0]           array_rdata,
  output logic                      wipe_start_q,
  output flash_pkg::wipe_req_t      wipe_req_q
);
  // -------------------------------------------------------------------
  // functions
  // -------------------------------------------------------------------
  function automatic logic [4:0] boot_delay(input logic [1:0] sel);
    unique case (sel)
      2'h0: boot_delay = flash_pkg::DLY_SEL0;
      2'h1: boot_delay = flash_pkg::DLY_SEL1;
      2'h2: boot_delay = flash_pkg::DLY_SEL2;
      2'h3: boot_delay = flash_pkg::DLY_SEL3;
    endcase
  endfunction

  function automatic logic guarded(input logic [23:0] a, input logic sch,
                                   input logic [3:0] bp,
                                   input logic [255:0] lock);
    logic [15:0] span;
    span = 16'h0001 << (bp - 4'h1);
    if (sch)
      guarded = lock[a[23:16]];
    else
      guarded = (bp != 4'h0) && ({8'h00, ~a[23:16]} < span);
  endfunction

  function automatic logic is_wipe(input logic [7:0] op);
    is_wipe = (op == flash_pkg::OP_SECTOR) || (op == flash_pkg::OP_HALF)
           || (op == flash_pkg::OP_BLOCK);
  endfunction

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [1:0] cs_s_q, sclk_s_q;
  logic [3:0] io_s1_q, io_s2_q;
  logic       cs_prev_q, sclk_prev_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cs_s_q      <= 2'h3;
      sclk_s_q    <= 2'h0;
      io_s1_q     <= 4'h0;
      io_s2_q     <= 4'h0;
      cs_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_s_q      <= {cs_s_q[0], cs_n};
      sclk_s_q    <= {sclk_s_q[0], sclk};
      io_s1_q     <= io_in;
      io_s2_q     <= io_s1_q;
      cs_prev_q   <= cs_s_q[1];
      sclk_prev_q <= sclk_s_q[1];
    end
  end
  logic cs_fall, cs_rise, sclk_rise, sclk_fall;
  assign cs_fall   = cs_prev_q & ~cs_s_q[1];
  assign cs_rise   = ~cs_prev_q & cs_s_q[1];
  assign sclk_rise = ~sclk_prev_q & sclk_s_q[1];
  assign sclk_fall = sclk_prev_q & ~sclk_s_q[1];

  // -------------------------------------------------------------------
  // two-entry boot data buffer
  // -------------------------------------------------------------------
  logic [7:0] buf_q [2];
  logic [7:0] buf_d [2];
  logic       wp_q, wp_d, rp_q, rp_d, armed_q, rearm_q, pop;
  logic [1:0] fcnt_q, fcnt_d;
  logic [23:0] addr_d;
  logic        rd_d, in_valid, in_ready, out_valid;
  assign in_valid  = array_rd_q & ~rearm_q;
  assign in_ready  = fcnt_q != 2'h2;
  assign out_valid = fcnt_q != 2'h0;
  always_comb begin
    buf_d  = buf_q;
    wp_d   = wp_q;
    rp_d   = rp_q;
    fcnt_d = fcnt_q;
    addr_d = array_addr_q;
    // a pending read blocks the next, so a push never meets a full buffer
    rd_d   = armed_q & ~array_rd_q & in_ready & ~rearm_q;
    // step past the byte only once its read has been presented, so the
    // first fetch after a rearm uses the start address itself
    if (array_rd_q)
      addr_d = array_addr_q + 24'h000001;
    if (in_valid && in_ready) begin
      buf_d[wp_q] = array_rdata;
      wp_d        = ~wp_q;
    end
    if (pop && out_valid)
      rp_d = ~rp_q;
    fcnt_d = fcnt_q + {1'b0, in_valid & in_ready}
                    - {1'b0, pop & out_valid};
    if (rearm_q) begin
      wp_d   = 1'b0;
      rp_d   = 1'b0;
      fcnt_d = 2'h0;
      addr_d = 24'({cfg_q[31:flash_pkg::SA_LSB], flash_pkg::SA_PAD}); // R2 R7
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      buf_q[0]     <= 8'h00;
      buf_q[1]     <= 8'h00;
      wp_q         <= 1'b0;
      rp_q         <= 1'b0;
      fcnt_q       <= 2'h0;
      array_rd_q   <= 1'b0;
      array_addr_q <= 24'h000000;
    end else begin
      buf_q        <= buf_d;
      wp_q         <= wp_d;
      rp_q         <= rp_d;
      fcnt_q       <= fcnt_d;
      array_rd_q   <= rd_d;
      array_addr_q <= addr_d;
    end
  end
  logic [7:0] head;
  assign head = out_valid ? buf_q[rp_q] : 8'hFF;

  // -------------------------------------------------------------------
  // serial framing
  // -------------------------------------------------------------------
  flash_pkg::state_t st_q, st_d;
  logic [31:0] sh_q, sh_d, out_q, out_d;
  logic [5:0]  cnt_q, cnt_d, step;
  logic [7:0]  op_q, op_d;
  logic [3:0]  io_out_d, io_oe_d;
  logic        stream_q, stream_d, enh_d, wout;
  assign step = quad_command_mode ? flash_pkg::STEP_QUAD
                                  : flash_pkg::STEP_ONE; // R15
  assign wout = stream_q ? quad_enable : quad_command_mode; // R5
  always_comb begin
    st_d     = st_q;
    sh_d     = sh_q;
    cnt_d    = cnt_q;
    op_d     = op_q;
    out_d    = out_q;
    io_out_d = io_out_q;
    io_oe_d  = io_oe_q;
    stream_d = stream_q;
    enh_d    = enhance_q;
    pop      = 1'b0;
    unique case (st_q)
      flash_pkg::ST_IDLE: begin
        if (cs_fall) begin
          cnt_d = flash_pkg::BITS_NONE;
          st_d  = armed_q ? flash_pkg::ST_BOOT : flash_pkg::ST_CMD; // R1
        end
      end
      flash_pkg::ST_CMD, flash_pkg::ST_ARG: begin
        if (sclk_rise) begin
          // upper lines are ignored in single-line mode
          sh_d = quad_command_mode ? {sh_q[27:0], io_s2_q}
                                   : {sh_q[30:0], io_s2_q[0]}; // R15
          if (cnt_q < flash_pkg::BITS_MAX)
            cnt_d = cnt_q + step;
          if (st_q == flash_pkg::ST_CMD && cnt_d == flash_pkg::BITS_OP) begin
            op_d  = sh_d[7:0];
            cnt_d = flash_pkg::BITS_NONE;
            st_d  = flash_pkg::ST_ARG;
            if (sh_d[7:0] == flash_pkg::OP_CFG_READ) begin
              st_d     = flash_pkg::ST_OUT; // R9
              out_d    = cfg_q;
              stream_d = 1'b0;
            end
          end
          if (st_q == flash_pkg::ST_ARG && op_q == flash_pkg::OP_QREAD
              && cnt_d == flash_pkg::BITS_WORD)
            enh_d = quad_command_mode & (&(sh_d[7:4] ^ sh_d[3:0])); // R20
        end
      end
      flash_pkg::ST_BOOT: begin
        if (sclk_rise) begin
          cnt_d = cnt_q + flash_pkg::STEP_ONE;
          if (cnt_d[4:0] ==
              boot_delay(cfg_q[flash_pkg::DLY_MSB:flash_pkg::DLY_LSB])) begin
            st_d     = flash_pkg::ST_OUT; // R2 R3 R6
            out_d    = {head, 24'h000000};
            pop      = 1'b1;
            stream_d = 1'b1;
            cnt_d    = flash_pkg::BITS_NONE;
          end
        end
      end
      flash_pkg::ST_OUT: begin
        if (sclk_fall) begin
          io_oe_d  = wout ? flash_pkg::OE_QUAD : flash_pkg::OE_SINGLE; // R5
          io_out_d = wout ? out_q[31:28] : {2'h0, out_q[31], 1'b0};
          out_d    = wout ? {out_q[27:0], 4'h0} : {out_q[30:0], 1'b0};
          cnt_d    = cnt_q + (wout ? flash_pkg::STEP_QUAD
                                   : flash_pkg::STEP_ONE);
          if (stream_q && cnt_d == flash_pkg::BITS_OP) begin
            out_d = {head, 24'h000000};
            pop   = 1'b1;
            cnt_d = flash_pkg::BITS_NONE;
          end
        end
      end
      default: st_d = flash_pkg::ST_IDLE;
    endcase
    if (cs_rise) begin
      st_d     = flash_pkg::ST_IDLE; // R3
      io_oe_d  = 4'h0;
      stream_d = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q      <= flash_pkg::ST_IDLE;
      sh_q      <= 32'h00000000;
      cnt_q     <= 6'h00;
      op_q      <= 8'h00;
      out_q     <= 32'h00000000;
      io_out_q  <= 4'h0;
      io_oe_q   <= 4'h0;
      stream_q  <= 1'b0;
      enhance_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      sh_q      <= sh_d;
      cnt_q     <= cnt_d;
      op_q      <= op_d;
      out_q     <= out_d;
      io_out_q  <= io_out_d;
      io_oe_q   <= io_oe_d;
      stream_q  <= stream_d;
      enhance_q <= enh_d;
    end
  end

  // -------------------------------------------------------------------
  // command execution and self-timed cycles
  // -------------------------------------------------------------------
  logic [31:0] cfg_d;
  logic [23:0] tmr_q, tmr_d, wa;
  logic        wip_d, wel_d, armed_d, rearm_d, go_d, exec, ok;
  flash_pkg::wipe_req_t req_d;
  logic [3:0]  dummy_d;
  assign exec = cs_rise && st_q == flash_pkg::ST_ARG;
  assign ok   = exec && wel_q && !wip_q; // R22
  always_comb begin
    cfg_d   = cfg_q;
    tmr_d   = tmr_q;
    wip_d   = wip_q;
    wel_d   = wel_q;
    armed_d = armed_q;
    rearm_d = 1'b0;
    go_d    = 1'b0;
    req_d   = wipe_req_q;
    wa      = sh_q[23:0];
    unique case (dummy_count_select) // R21
      2'h0: dummy_d = DUMMY0;
      2'h1: dummy_d = DUMMY1;
      2'h2: dummy_d = DUMMY2;
      2'h3: dummy_d = DUMMY3;
    endcase
    if (rearm_q)
      armed_d = ~cfg_q[flash_pkg::CFG_EN_BIT]; // R1 R8
    if (cs_rise && armed_q)
      armed_d = 1'b0; // R3
    if (wip_q) begin
      tmr_d = tmr_q - 24'h000001;
      if (tmr_q == 24'h000001) begin
        wip_d = 1'b0; // R16
        wel_d = 1'b0;
      end
    end
    if (exec && !wip_q && cnt_q == flash_pkg::BITS_NONE) begin
      if (op_q == flash_pkg::OP_LATCH_SET)
        wel_d = 1'b1; // R11
      if (op_q == flash_pkg::OP_RESET)
        rearm_d = 1'b1; // R1
    end
    if (ok && op_q == flash_pkg::OP_CFG_ERASE
        && cnt_q == flash_pkg::BITS_NONE) begin
      cfg_d = flash_pkg::CFG_ERASED; // R9
      wip_d = 1'b1;
      tmr_d = 24'(CFG_CYC);
    end
    if (ok && op_q == flash_pkg::OP_CFG_PROG
        && cnt_q == flash_pkg::BITS_WORD) begin
      cfg_d = cfg_q & sh_q; // R9
      wip_d = 1'b1;
      tmr_d = 24'(CFG_CYC);
    end
    // any other bit count means select rose off the end of the third address byte
    if (ok && is_wipe(op_q) && cnt_q == flash_pkg::BITS_ADDR) begin // R13
      if (op_q == flash_pkg::OP_SECTOR) begin
        wa         = wa & flash_pkg::SECTOR_MASK; // R12
        req_d.kind = flash_pkg::WIPE_SECTOR;
        tmr_d      = 24'(SECTOR_CYC);
      end else if (op_q == flash_pkg::OP_HALF) begin
        wa         = wa & flash_pkg::HALF_MASK; // R18
        req_d.kind = flash_pkg::WIPE_HALF;
        tmr_d      = 24'(HALF_CYC);
      end else begin
        wa         = wa & flash_pkg::BLOCK_MASK; // R19
        req_d.kind = flash_pkg::WIPE_BLOCK;
        tmr_d      = 24'(BLOCK_CYC);
      end
      req_d.addr = wa;
      if (!guarded(wa, protect_scheme_select, protect_level_bits,
                   sector_lock_bits)) begin // R17
        go_d  = 1'b1;
        wip_d = 1'b1; // R16
      end else begin
        tmr_d = tmr_q;
      end
    end
  end
  // config survives the reset command; only power-on reset and the erase command return it to erased
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q        <= flash_pkg::CFG_ERASED;
      tmr_q        <= 24'h000000;
      wip_q        <= 1'b0;
      wel_q        <= 1'b0;
      armed_q      <= 1'b0;
      rearm_q      <= 1'b1;
      wipe_start_q <= 1'b0;
      wipe_req_q   <= '0;
      read_dummy_q <= 4'h0;
    end else begin
      cfg_q        <= cfg_d;
      tmr_q        <= tmr_d;
      wip_q        <= wip_d;
      wel_q        <= wel_d;
      armed_q      <= armed_d;
      rearm_q      <= rearm_d;
      wipe_start_q <= go_d;
      wipe_req_q   <= req_d;
      read_dummy_q <= dummy_d;
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_wipe_go;
    wipe_start_q ##0 wip_q;
  endsequence
  chk_wipe_latch: assert property ( // R11 R22
    wipe_start_q |-> $past(wel_q) && !$past(wip_q))
    else $error("erase began without write latch");
  chk_wip_hold: assert property ( // R16
    wipe_start_q |-> s_wipe_go)
    else $error("progress flag not set on erase");
  chk_wip_end: assert property ( // R16
    $fell(wip_q) |-> !wel_q)
    else $error("write latch left set after cycle");
  chk_sector_align: assert property ( // R12
    wipe_start_q && wipe_req_q.kind == flash_pkg::WIPE_SECTOR
    |-> wipe_req_q.addr[11:0] == 12'h000)
    else $error("sector address not aligned");
  chk_guard_skip: assert property ( // R17
    wipe_start_q |-> !guarded(wipe_req_q.addr, protect_scheme_select,
                               protect_level_bits, sector_lock_bits))
    else $error("erase started on guarded block");
  chk_byte_edge: assert property ( // R13
    wipe_start_q |-> $past(cnt_q) == flash_pkg::BITS_ADDR)
    else $error("erase accepted off byte boundary");
  chk_boot_disarm: assert property ( // R3
    cs_rise && armed_q |=> !armed_q && st_q == flash_pkg::ST_IDLE)
    else $error("boot state kept after select rise");
  chk_boot_delay: assert property ( // R2 R6
    $rose(stream_q) |-> $past(cnt_q[4:0]) == 5'(boot_delay(
      cfg_q[flash_pkg::DLY_MSB:flash_pkg::DLY_LSB]) - 5'h01))
    else $error("boot delay count wrong");
  chk_boot_lines: assert property ( // R5
    stream_q && io_oe_q != 4'h0
    |-> io_oe_q == (quad_enable ? flash_pkg::OE_QUAD
                                : flash_pkg::OE_SINGLE))
    else $error("boot stream line count wrong");
endmodule

// >>> flash_pkg.sv
package flash_pkg;
  // -------------------------------------------------------------------
  // configuration word layout
  // -------------------------------------------------------------------
  localparam logic [31:0] CFG_ERASED = 32'hFFFFFFFF;
  localparam int CFG_EN_BIT = 0;
  localparam int DLY_LSB    = 1;
  localparam int DLY_MSB    = 2;
  localparam int SA_LSB     = 4;
  localparam logic [3:0] SA_PAD = 4'h0;
  localparam logic [4:0] DLY_SEL0 = 5'h07;
  localparam logic [4:0] DLY_SEL1 = 5'h09;
  localparam logic [4:0] DLY_SEL2 = 5'h0B;
  localparam logic [4:0] DLY_SEL3 = 5'h0D;
  // -------------------------------------------------------------------
  // opcodes (plain defaults)
  // -------------------------------------------------------------------
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_SECTOR    = 8'h20;
  localparam logic [7:0] OP_HALF      = 8'h52;
  localparam logic [7:0] OP_BLOCK     = 8'hD8;
  localparam logic [7:0] OP_RESET     = 8'h99;
  localparam logic [7:0] OP_CFG_PROG  = 8'h17;
  localparam logic [7:0] OP_CFG_ERASE = 8'h18;
  localparam logic [7:0] OP_CFG_READ  = 8'h16;
  localparam logic [7:0] OP_QREAD     = 8'hEB;
  // -------------------------------------------------------------------
  // bit counts and address masks
  // -------------------------------------------------------------------
  localparam logic [5:0] BITS_NONE = 6'h00;
  localparam logic [5:0] BITS_OP   = 6'h08;
  localparam logic [5:0] BITS_ADDR = 6'h18;
  localparam logic [5:0] BITS_WORD = 6'h20;
  localparam logic [5:0] BITS_MAX  = 6'h3C;
  localparam logic [5:0] STEP_ONE  = 6'h01;
  localparam logic [5:0] STEP_QUAD = 6'h04;
  localparam logic [23:0] SECTOR_MASK = 24'hFFF000;
  localparam logic [23:0] HALF_MASK   = 24'hFF8000;
  localparam logic [23:0] BLOCK_MASK  = 24'hFF0000;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_QUAD   = 4'hF;
  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD  = 5'h02,
    ST_ARG  = 5'h04,
    ST_BOOT = 5'h08,
    ST_OUT  = 5'h10
  } state_t;
  typedef enum logic [1:0] {
    WIPE_SECTOR = 2'h0,
    WIPE_HALF   = 2'h1,
    WIPE_BLOCK  = 2'h2
  } wipe_t;
  typedef struct packed {
    wipe_t       kind;
    logic [23:0] addr;
  } wipe_req_t;
endpackage

// >>> flash_host.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host controller on the serial link
// ---------------------------------------------------------------
module flash_host #(
  parameter int HALF = 4  // 400 ns link period, far under any limit
) (
  // system clock
  input  wire logic       clock,
  // link
  input  wire logic [3:0] io_out_q,
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      io_in
);
  initial begin
    cs_n  = 1'b1;
    sclk  = 1'b0;
    io_in = 4'hA;
  end

  task automatic tick();
    repeat (HALF) @(negedge clock);
  endtask

  // one framed transfer: d left aligned, n link cycles, q four lines
  task automatic frame(input logic [39:0] d, input int n,
                       input logic q, output logic [31:0] rd);
    logic [63:0] sr;
    sr = {d, 24'h0};
    rd = 32'h0;
    @(negedge clock);
    cs_n = 1'b0;
    tick();
    repeat (n) begin
      // spare lines toggle in single-line mode: the device must ignore them
      io_in = q ? sr[63:60] : {~io_in[3:1], sr[63]};
      sr = q ? sr << 4 : sr << 1;
      tick();
      sclk = 1'b1;
      tick();
      // sampled just before the fall, while the last bit still stands
      rd = q ? {rd[27:0], io_out_q} : {rd[30:0], io_out_q[1]};
      sclk = 1'b0;
    end
    tick();
    cs_n = 1'b1;
    // released lines must not show a stale value
    io_in = ~io_in;
    tick();
    tick();
  endtask
endmodule

// >>> serial_flash_boot_and_erase_tb_top.sv
`timescale 1ns/1ps
module serial_flash_boot_and_erase_tb_top;
  // -------------------------------------------------------------
  // signals and tables
  // -------------------------------------------------------------
  logic         clock, rst_b, cs_n, sclk, quad_enable, quad_command_mode;
  logic         protect_scheme_select, wip_q, wel_q, enhance_q;
  logic         array_rd_q, wipe_start_q;
  logic [1:0]   dummy_count_select;
  logic [3:0]   io_in, io_out_q, io_oe_q, protect_level_bits, read_dummy_q;
  logic [7:0]   array_rdata;
  logic [23:0]  array_addr_q;
  logic [31:0]  cfg_q, rd, word;
  logic [255:0] sector_lock_bits;
  int           bad_count, checks_done, starts, s0;
  flash_pkg::wipe_req_t wipe_req_q, req_seen;
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic        q, pss;
    logic [3:0]  plb;
    logic [8:0]  lock;
    logic        go;
    logic [1:0]  kind;
  } erase_row_t;
  typedef struct packed {
    logic [1:0]  sel;
    logic        q;
    logic [27:0] sa;
  } boot_row_t;
  erase_row_t rows [6] = '{
    '{flash_pkg::OP_SECTOR, 24'h123456, 1'b0, 1'b0, 4'h0, 9'h000, 1'b1, 2'h0},
    '{flash_pkg::OP_HALF, 24'h12FFFF, 1'b1, 1'b0, 4'h0, 9'h000, 1'b1, 2'h1},
    '{flash_pkg::OP_BLOCK, 24'h3ABCDE, 1'b0, 1'b1, 4'h0, 9'h13B, 1'b1, 2'h2},
    '{flash_pkg::OP_SECTOR, 24'hFF0010, 1'b0, 1'b0, 4'h1, 9'h000, 1'b0, 2'h0},
    '{flash_pkg::OP_BLOCK, 24'h7F0000, 1'b1, 1'b1, 4'h0, 9'h17F, 1'b0, 2'h2},
    '{flash_pkg::OP_HALF, 24'hFF7FFF, 1'b0, 1'b1, 4'h1, 9'h000, 1'b1, 2'h1}};
  boot_row_t boots [4] = '{'{2'h0, 1'b0, 28'h0000012},
    '{2'h1, 1'b1, 28'h00ABC01}, '{2'h2, 1'b0, 28'h0000FFF},
    '{2'h3, 1'b1, 28'hFFFFFF0}};
  logic [3:0] dummies [4] = '{4'h6, 4'h4, 4'h8, 4'hA};

  flash_seq #(.SECTOR_CYC(60), .HALF_CYC(80), .BLOCK_CYC(100),
    .CFG_CYC(40)) dut (
    .clock(clock), .rst_b(rst_b), .cs_n(cs_n), .sclk(sclk),
    .io_in(io_in), .io_out_q(io_out_q), .io_oe_q(io_oe_q),
    .quad_enable(quad_enable), .quad_command_mode(quad_command_mode),
    .protect_scheme_select(protect_scheme_select),
    .protect_level_bits(protect_level_bits),
    .sector_lock_bits(sector_lock_bits),
    .dummy_count_select(dummy_count_select), .wip_q(wip_q),
    .wel_q(wel_q), .enhance_q(enhance_q), .read_dummy_q(read_dummy_q),
    .cfg_q(cfg_q), .array_rd_q(array_rd_q), .array_addr_q(array_addr_q),
    .array_rdata(array_rdata), .wipe_start_q(wipe_start_q),
    .wipe_req_q(wipe_req_q));

  flash_host host (.clock(clock), .io_out_q(io_out_q), .cs_n(cs_n),
    .sclk(sclk), .io_in(io_in));

  // -------------------------------------------------------------
  // clock, array model, erase monitor
  // -------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // pattern keyed by address, so a wrong start shows as wrong data
  always @(negedge clock) begin
    if (array_rd_q === 1'b1) array_rdata <= array_addr_q[7:0] ^ 8'h5A;
  end

  // the start pulse is one cycle wide, so it is caught here, not polled
  always @(negedge clock) begin
    if (wipe_start_q === 1'b1) begin
      starts++;
      req_seen = wipe_req_q;
    end
  end

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [39:0] d, input int bits);
    host.frame(d, quad_command_mode ? bits / 4 : bits, quad_command_mode, rd);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 400 && wip_q !== 1'b0; i++) @(negedge clock);
    chk(wip_q, 0);
  endtask

  function automatic logic [23:0] mask(input logic [1:0] k);
    return k == 2'h0 ? 24'hFFF000 : k == 2'h1 ? 24'hFF8000 : 24'hFF0000;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #2000000;
    bad_count++;
    finish_test();
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    {quad_enable, quad_command_mode, protect_scheme_select} = 3'h0;
    protect_level_bits = 4'h0;
    sector_lock_bits = 256'h0;
    dummy_count_select = 2'h0;
    array_rdata = 8'h00;
    repeat (8) @(negedge clock);
    chk(cfg_q, 32'hFFFFFFFF);
    chk({wip_q, wel_q}, 0);
    rst_b = 1'b1;
    repeat (6) @(negedge clock);
    $display("test reset done");
    foreach (rows[i]) begin
      quad_command_mode = rows[i].q;
      protect_scheme_select = rows[i].pss;
      protect_level_bits = rows[i].plb;
      sector_lock_bits = rows[i].lock[8] ? 256'h1 << rows[i].lock[7:0] : 0;
      s0 = starts;
      cmd({flash_pkg::OP_LATCH_SET, 32'h0}, 8);
      chk(wel_q, 1);
      cmd({rows[i].op, rows[i].addr, 8'h0}, 32);
      chk(wip_q, rows[i].go);
      wait_idle();
      chk(starts - s0, rows[i].go);
      chk(wel_q, !rows[i].go);
      if (rows[i].go)
        chk(req_seen, {rows[i].kind, rows[i].addr & mask(rows[i].kind)});
      $display("test erase row %0d done", i);
    end
    quad_command_mode = 1'b0;
    s0 = starts;
    cmd({flash_pkg::OP_SECTOR, 32'h0}, 32);
    chk({wip_q, wel_q}, 0);
    cmd({flash_pkg::OP_LATCH_SET, 32'h0}, 8);
    cmd({flash_pkg::OP_BLOCK, 24'h010000, 8'h0}, 31);
    chk({30'(starts - s0), wip_q, wel_q}, 1);
    $display("test refused erases done");
    for (int k = 0; k < 4; k++) begin
      dummy_count_select = k[1:0];
      repeat (4) @(negedge clock);
      chk(read_dummy_q, dummies[k]);
    end
    {quad_enable, quad_command_mode} = 2'h3;
    cmd({8'hEB, 24'h1234FF, 8'hA5}, 56);
    chk(enhance_q, 1);
    // address low byte FF keeps the indicator FF either way it is framed
    cmd({8'hEB, 24'h1234FF, 8'hFF}, 56);
    chk(enhance_q, 0);
    quad_command_mode = 1'b0;
    $display("test dummy and enhance done");
    foreach (boots[i]) begin
      word = {boots[i].sa, 1'b1, boots[i].sel, 1'b0};
      quad_enable = boots[i].q;
      cmd({flash_pkg::OP_LATCH_SET, 32'h0}, 8);
      cmd({flash_pkg::OP_CFG_ERASE, 32'h0}, 8);
      wait_idle();
      chk(cfg_q, 32'hFFFFFFFF);
      cmd({flash_pkg::OP_LATCH_SET, 32'h0}, 8);
      cmd({flash_pkg::OP_CFG_PROG, word}, 40);
      wait_idle();
      chk(cfg_q, word);
      cmd({flash_pkg::OP_CFG_READ, 32'h0}, 40);
      chk(rd, word);
      cmd({flash_pkg::OP_RESET, 32'h0}, 8);
      repeat (8) @(negedge clock);
      host.frame(40'h0, 7 + 2 * boots[i].sel + (boots[i].q ? 2 : 8),
                 boots[i].q, rd);
      chk(rd[7:0], {boots[i].sa[3:0], 4'h0} ^ 8'h5A);
      chk(io_oe_q, 0);
      cmd({flash_pkg::OP_LATCH_SET, 32'h0}, 8);
      chk(wel_q, 1);
      $display("test boot row %0d done", i);
    end
    finish_test();
  end
endmodule
